/* pkg/hpm_pkg.sv */
// constants for the host/pci memory decode block
package hpm_pkg;
   localparam int AW          = 36;             // host address width
   localparam int MBW         = AW - 20;        // address in 1 MB units
   localparam int SMW         = AW - 16;        // address in 64 KB units
   // fixed compatibility windows
   localparam logic [AW-1:0] VGA_LO   = 36'h0_000a_0000;
   localparam logic [AW-1:0] VGA_HI   = 36'h0_000b_ffff;
   localparam logic [AW-1:0] FIX_LO   = 36'h0_000c_0000;
   localparam logic [AW-1:0] FIX_HI   = 36'h0_000e_ffff;
   localparam logic [5:0]    FIX_BLK0 = 6'h30;  // c0000 in 16 KB blocks
   localparam int            FIX_NUM  = 12;     // 16 KB blocks to effff
   localparam logic [AW-1:0] BIOS_LO  = 36'h0_000f_0000;
   localparam logic [AW-1:0] BIOS_HI  = 36'h0_000f_ffff;
   // range left to local memory
   localparam logic [AW-1:0] LOC_LO   = 36'h0_fed0_0000;
   localparam logic [AW-1:0] LOC_HI   = 36'h0_ffdf_ffff;
   // window size codes: 1,2,4,8,16,32 MB
   localparam logic [2:0]    SIZE_MAX = 3'h5;
   localparam logic [MBW-1:0] GAP_MIN = 16'h0001;  // 1 MB
   localparam logic [11:0]   FB_MIN   = 12'h400;    // 1 GB in MB
   localparam logic [11:0]   FB_MAX   = 12'hfff;    // last MB below 4 GB
   localparam logic [4:0]    SMM_MAX  = 5'h10;      // 1 MB in 64 KB units
   // in-order queue and time-out
   localparam int            IOQ_DEPTH = 8;
   localparam int            TOW       = 16;
   localparam logic [1:0]    STRAP_DLY = 2'h2;      // synchroniser depth
endpackage

/* hw/hpm_decode.sv */
// host/pci memory claim decode with smm tracking and host time-out
//
// Contract
// - host-to-pci windows make pci access ignored
// - pci-to-host accesses never claimed on host
// - compatibility bridge answers unclaimed host requests
// - only 36-bit host addresses, larger refused
// - per-region attributes gate fixed-region claims
// - video enable gates a0000-bffff decode
// - top-of-memory enable claims above main memory in the compatibility role
// - gap window 1 MB aligned, 1-32 MB
// - high gap has programmable start and end
// - boot rom block, reset enable follows bridge role
// - fed00000-ffdfffff stays local with two exceptions
// - frame buffer 1-4 GB, 1-32 MB size
// - smm flagged accesses in smm window unclaimed
// - smm window 64 KB steps, up to 1 MB
// - smm window overrides top-of-memory for normal accesses
// - sm acknowledge answered in the compatibility role, active set with flag
// - smm active held until unflagged acknowledge
// - window hits claimed unless kept local, else below top left
// - timed-out host requests retired in the compatibility role, not forwarded
// - pci below top forwarded unless window hit
// - pci above top forwarded to host unless window hit
// - restricted variant never forwards pci i/o
// - time-out logged when queue waits too long
`timescale 1ns/10ps
module hpm_decode
   import hpm_pkg::*;
#(
   parameter bit FULL_IO = 1'b0   // 1: pci i/o may go to host
) (
   // clock and reset
   input  wire logic           clk_in,
   input  wire logic           sys_rst_in,
   // strap: high in the compatibility bridge
   input  wire logic           compat_strap_in,
   // host request, sampled on host_req_in
   input  wire logic           host_req_in,
   input  wire logic [AW-1:0]  host_addr_in,
   input  wire logic           host_addr_wide_in,  // address beyond 36 bits
   input  wire logic           host_write_in,
   input  wire logic           host_io_in,
   input  wire logic           host_sm_ack_in,
   input  wire logic           mgmt_mode_request_flag_in,
   input  wire logic           host_resp_seen_in,  // any response phase
   // pci request
   input  wire logic           pci_req_in,
   input  wire logic [AW-1:0]  pci_addr_in,
   input  wire logic           pci_io_in,
   // decode configuration
   input  wire logic [2*FIX_NUM-1:0] fixed_region_attribute_map_in,
   input  wire logic           video_buffer_enable_in,
   input  wire logic           top_of_memory_enable_in,
   input  wire logic [MBW-1:0] top_of_memory_limit_in,
   input  wire logic           memory_gap_enable_in,
   input  wire logic [MBW-1:0] memory_gap_upper_address_in,
   input  wire logic [2:0]     memory_gap_size_in,
   input  wire logic           high_gap_enable_in,
   input  wire logic [MBW-1:0] high_gap_start_in,
   input  wire logic [MBW-1:0] high_gap_end_in,
   input  wire logic           boot_rom_write_in,  // load boot rom enable
   input  wire logic           boot_rom_value_in,
   input  wire logic           interrupt_controller_range_en_in,
   input  wire logic           frame_buffer_enable_in,
   input  wire logic [11:0]    frame_buffer_window_in,
   input  wire logic [2:0]     frame_buffer_size_in,
   input  wire logic           mgmt_ram_enable_in,
   input  wire logic [SMW-1:0] mgmt_ram_window_in,
   input  wire logic [4:0]     mgmt_ram_units_in,  // 64 KB units, 1..16
   input  wire logic [TOW-1:0] timeout_value_in,   // 0 disables
   input  wire logic           timeout_log_clr_in,
   // host answers
   output logic                host_resp_vld_out,
   output logic                host_claim_out,
   output logic                host_unsup_out,
   output logic                sm_ack_resp_out,
   output logic                mgmt_mode_active_out,
   output logic                host_retire_out,
   output logic                timeout_log_out,
   output logic                boot_rom_enable_out,
   // pci answer
   output logic                pci_resp_vld_out,
   output logic                pci_fwd_host_out
);
   // decode indexes the map with 4 bits of the block index, so the map must fit
   if (FIX_NUM > 16) begin : g_bad
      $error("fixed region count too large");
   end

   // inclusive range test
   function automatic logic in_rng(input logic [AW-1:0] a,
                                   input logic [AW-1:0] lo,
                                   input logic [AW-1:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // 1 MB aligned window of 2**sel MB; base 0 and bad codes never hit
   function automatic logic in_win(input logic [MBW-1:0] amb,
                                   input logic [MBW-1:0] base,
                                   input logic [2:0]     sel);
      logic [MBW:0] top;
      top = {1'b0, base} + ({{MBW{1'b0}}, 1'b1} << sel);
      return (sel <= SIZE_MAX) && (base >= GAP_MIN) &&
             (amb >= base) && ({1'b0, amb} < top);
   endfunction

   // registered state
   logic                strap_s1_reg, strap_s2_reg;  // strap synchroniser
   logic [1:0]          init_cnt_reg;
   logic                compat_reg;     // role caught after release
   logic [3:0]          ioq_cnt_reg;    // outstanding host requests
   logic [TOW-1:0]      to_cnt_reg;     // cycles without response

   // window decode shared by both sides
   function automatic logic win_hit(input logic [AW-1:0] a,
                                    input logic          wr,
                                    input logic          bios_en);
      logic [MBW-1:0] amb;
      logic [5:0]     idx;
      logic [1:0]     attr;
      logic           hit;
      amb  = a[AW-1:20];
      idx  = a[19:14] - FIX_BLK0;
      attr = fixed_region_attribute_map_in[{idx[3:0], 1'b0} +: 2];
      hit  = 1'b0;
      // attr bit 0 claims reads, bit 1 claims writes
      // attribute gated claim
      if (in_rng(a, FIX_LO, FIX_HI))
         hit = wr ? attr[1] : attr[0];
      if (in_rng(a, VGA_LO, VGA_HI) && video_buffer_enable_in)
         hit = 1'b1;
      if (in_rng(a, BIOS_LO, BIOS_HI) && bios_en)
         hit = 1'b1;
      if (memory_gap_enable_in &&
          in_win(amb, memory_gap_upper_address_in, memory_gap_size_in))
         hit = 1'b1;
      if (high_gap_enable_in && high_gap_start_in >= GAP_MIN &&
          amb >= high_gap_start_in && amb <= high_gap_end_in)
         hit = 1'b1;
      if (frame_buffer_enable_in && a[AW-1:32] == 4'h0 &&
          frame_buffer_window_in >= FB_MIN &&
          in_win({4'h0, a[31:20]}, {4'h0, frame_buffer_window_in},
                 frame_buffer_size_in))
         hit = 1'b1;
      return hit;
   endfunction

   // host side decode, all from values present at the request edge
   wire [MBW-1:0] h_mb       = host_addr_in[AW-1:20];
   wire           h_above    = h_mb >= top_of_memory_limit_in;
   wire           h_win      = win_hit(host_addr_in, host_write_in,
                                       boot_rom_enable_out);
   wire [SMW:0]   smm_top    = {1'b0, mgmt_ram_window_in} +
                               {{(SMW-4){1'b0}}, mgmt_ram_units_in};
   // 64 KB steps, at most 1 MB
   wire           smm_ok     = mgmt_ram_enable_in &&
                               mgmt_ram_units_in != 5'h00 &&
                               mgmt_ram_units_in <= SMM_MAX;
   wire           h_in_smm   = smm_ok &&
                               host_addr_in[AW-1:16] >= mgmt_ram_window_in &&
                               {1'b0, host_addr_in[AW-1:16]} < smm_top;
   wire           h_gap_hit  = memory_gap_enable_in &&
                               in_win(h_mb, memory_gap_upper_address_in,
                                      memory_gap_size_in);
   // local hole unless above top or gap with both ranges off
   wire           h_local    = in_rng(host_addr_in, LOC_LO, LOC_HI) &&
                               !h_above &&
                               !(h_gap_hit && !boot_rom_enable_out &&
                                 !interrupt_controller_range_en_in);
   // default responder takes memory above top
   wire           h_tom      = compat_reg && top_of_memory_enable_in &&
                               h_above;
   wire           h_mem_clm  = h_in_smm ? !mgmt_mode_request_flag_in :
                               (!h_local && (h_win || h_tom));
   // host i/o goes down to pci unless its address is beyond 36 bits
   wire           h_claim    = !host_addr_wide_in &&
                               (host_io_in || h_mem_clm);

   // pci side decode: window hits stay on pci
   wire           p_win      = win_hit(pci_addr_in, 1'b0,
                                       boot_rom_enable_out);
   // pci memory forwarded unless a window keeps it, pci i/o only with FULL_IO
   wire           p_fwd      = pci_io_in ? FULL_IO : !p_win;

   // time-out detection
   wire           ioq_empty  = ioq_cnt_reg == 4'h0;
   wire           timeout    = !ioq_empty && !host_resp_seen_in &&
                               timeout_value_in != '0 &&
                               to_cnt_reg == timeout_value_in;
   wire           req_take   = host_req_in && !host_addr_wide_in &&
                               ioq_cnt_reg < 4'(IOQ_DEPTH);
   wire           ioq_pop    = host_resp_seen_in || timeout;

   // strap synchroniser, role loaded once after release
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         strap_s1_reg <= 1'b0;
         strap_s2_reg <= 1'b0;
         init_cnt_reg <= 2'h0;
         compat_reg   <= 1'b0;
      end else begin
         strap_s1_reg <= compat_strap_in;
         strap_s2_reg <= strap_s1_reg;
         // parks one past the load, so the role is taken only once
         if (init_cnt_reg != STRAP_DLY + 2'h1) begin
            init_cnt_reg <= init_cnt_reg + 2'h1;
         end
         if (init_cnt_reg == STRAP_DLY) begin
            compat_reg <= strap_s2_reg;
         end
      end
   end

   // boot rom enable: role default, then software loads
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         boot_rom_enable_out <= 1'b0;
      end else if (init_cnt_reg == STRAP_DLY) begin
         boot_rom_enable_out <= strap_s2_reg;
      end else if (boot_rom_write_in) begin
         boot_rom_enable_out <= boot_rom_value_in;
      end
   end

   // host and pci answers, one cycle after the request
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         host_resp_vld_out <= 1'b0;
         host_claim_out    <= 1'b0;
         host_unsup_out    <= 1'b0;
         sm_ack_resp_out   <= 1'b0;
         pci_resp_vld_out  <= 1'b0;
         pci_fwd_host_out  <= 1'b0;
      end else begin
         host_resp_vld_out <= host_req_in;
         host_claim_out    <= host_req_in && !host_sm_ack_in && h_claim;
         host_unsup_out    <= host_req_in && host_addr_wide_in;
         sm_ack_resp_out   <= host_req_in && host_sm_ack_in && compat_reg;
         pci_resp_vld_out  <= pci_req_in;
         // pci-bound host traffic never loops back
         pci_fwd_host_out  <= pci_req_in && p_fwd;
      end
   end

   // smm active tracking
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mgmt_mode_active_out <= 1'b0;
      // every acknowledge in the compatibility role reloads from the flag
      end else if (host_req_in && host_sm_ack_in && compat_reg) begin
         mgmt_mode_active_out <= mgmt_mode_request_flag_in;
      end
   end

   // queue occupancy and wait counter
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ioq_cnt_reg <= 4'h0;
         to_cnt_reg  <= '0;
      end else begin
         ioq_cnt_reg <= ioq_cnt_reg + 4'(req_take) -
                        4'(ioq_pop && !ioq_empty);
         // count restarts on any response or when idle
         if (ioq_empty || ioq_pop) begin
            to_cnt_reg <= '0;
         end else if (to_cnt_reg != '1) begin
            to_cnt_reg <= to_cnt_reg + TOW'(1);
         end
      end
   end

   // time-out log and retire; a new event beats the clear
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         timeout_log_out <= 1'b0;
         host_retire_out <= 1'b0;
      end else begin
         timeout_log_out <= timeout ||
                            (timeout_log_out && !timeout_log_clr_in);
         // default responder retires, nothing sent to pci
         host_retire_out <= timeout && compat_reg;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   a_wide_refused: assert property (
      host_req_in && host_addr_wide_in |=> host_unsup_out && !host_claim_out)
      else $error("wide host address was claimed");
   a_smm_ignored: assert property (
      host_req_in && !host_sm_ack_in && !host_addr_wide_in && !host_io_in &&
      h_in_smm && mgmt_mode_request_flag_in |=> !host_claim_out)
      else $error("smm access in smm window was claimed");
   a_smm_normal: assert property (
      host_req_in && !host_sm_ack_in && !host_addr_wide_in && h_in_smm &&
      !mgmt_mode_request_flag_in |=> host_claim_out)
      else $error("normal access in smm window not claimed");
   a_local_left: assert property (
      host_req_in && !host_io_in && !h_win && !h_above && !h_in_smm
      |=> !host_claim_out)
      else $error("main memory access was claimed");
   a_ack_set: assert property (
      host_req_in && host_sm_ack_in && mgmt_mode_request_flag_in &&
      compat_reg |=> sm_ack_resp_out ##0 mgmt_mode_active_out)
      else $error("acknowledge did not set smm active");
   a_act_hold: assert property (
      mgmt_mode_active_out &&
      !(host_req_in && host_sm_ack_in && !mgmt_mode_request_flag_in)
      |=> mgmt_mode_active_out)
      else $error("smm active dropped early");
   a_pci_ignore: assert property (
      pci_req_in && !pci_io_in && p_win |=> pci_resp_vld_out &&
      !pci_fwd_host_out)
      else $error("pci access in host window forwarded");
   a_pci_io_blk: assert property (
      pci_req_in && pci_io_in && !FULL_IO |=> !pci_fwd_host_out)
      else $error("pci i/o forwarded in restricted variant");
   a_timeout_log: assert property (
      timeout |=> timeout_log_out ##0 $past(ioq_cnt_reg) != 4'h0)
      else $error("time-out not logged");
   a_retire_role: assert property (
      host_retire_out |-> compat_reg && $past(timeout))
      else $error("retire without time-out");
endmodule

/* test/hpm_host_agent.sv */
// host bus agent model that answers each request after a delay
`timescale 1ns/10ps
module hpm_host_agent (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   // observed request and controls
   input  wire logic       req_in,
   input  wire logic       mute_in,   // silent agent forces time-outs
   input  wire logic [3:0] delay_in,  // answer delay in cycles
   // response phase seen by the bridge
   output logic            resp_seen_out
);
   logic [15:0] pend_reg;  // one bit per past cycle, set where a request was seen
   // request history; one request a cycle keeps answers apart
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pend_reg <= 16'h0000;
      end else begin
         pend_reg <= {pend_reg[14:0], req_in};
      end
   end
   // mute drops answers outright, it does not delay them
   assign resp_seen_out = !mute_in && pend_reg[delay_in];
endmodule

/* test/tb_hpm_decode.sv */
// self-checking bench for the host/pci memory decode block
`timescale 1ns/10ps
module tb_hpm_decode;
   import hpm_pkg::*;
   // clock, reset, strap, agent controls
   logic                 clk_in, sys_rst_in, strap, mute, rsp;
   logic [3:0]           dly;
   // host and pci request fields
   logic                 hreq, wide, wr, io, ack, smf, preq, pio;
   logic [AW-1:0]        haddr, paddr;
   // decode configuration
   logic [2*FIX_NUM-1:0] fra;
   logic                 vbe, tom_en, gap_en, hg_en, br_wr, br_val;
   logic                 intc, fb_en, sm_en, clr;
   logic [MBW-1:0]       tom, gap_b, hg_lo, hg_hi;
   logic [2:0]           gap_sz, fb_sz;
   logic [11:0]          fb_b;
   logic [SMW-1:0]       sm_b;
   logic [4:0]           sm_u;
   logic [TOW-1:0]       tmo;
   // design outputs and captured pulses
   logic                 h_vld, h_clm, h_uns, sak, act, ret, tlog, br_en;
   logic                 p_vld, p_fwd, c_uns, c_sak;
   int                   error_cnt, samples_checked, n;

   hpm_decode #(.FULL_IO(1'b0)) hpm_decode_inst (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .compat_strap_in(strap),
      .host_req_in(hreq), .host_addr_in(haddr), .host_addr_wide_in(wide),
      .host_write_in(wr), .host_io_in(io), .host_sm_ack_in(ack),
      .mgmt_mode_request_flag_in(smf), .host_resp_seen_in(rsp),
      .pci_req_in(preq), .pci_addr_in(paddr), .pci_io_in(pio),
      .fixed_region_attribute_map_in(fra), .video_buffer_enable_in(vbe),
      .top_of_memory_enable_in(tom_en), .top_of_memory_limit_in(tom),
      .memory_gap_enable_in(gap_en), .memory_gap_upper_address_in(gap_b),
      .memory_gap_size_in(gap_sz), .high_gap_enable_in(hg_en),
      .high_gap_start_in(hg_lo), .high_gap_end_in(hg_hi),
      .boot_rom_write_in(br_wr), .boot_rom_value_in(br_val),
      .interrupt_controller_range_en_in(intc),
      .frame_buffer_enable_in(fb_en), .frame_buffer_window_in(fb_b),
      .frame_buffer_size_in(fb_sz), .mgmt_ram_enable_in(sm_en),
      .mgmt_ram_window_in(sm_b), .mgmt_ram_units_in(sm_u),
      .timeout_value_in(tmo), .timeout_log_clr_in(clr),
      .host_resp_vld_out(h_vld), .host_claim_out(h_clm),
      .host_unsup_out(h_uns), .sm_ack_resp_out(sak),
      .mgmt_mode_active_out(act), .host_retire_out(ret),
      .timeout_log_out(tlog), .boot_rom_enable_out(br_en),
      .pci_resp_vld_out(p_vld), .pci_fwd_host_out(p_fwd));

   hpm_host_agent hpm_host_agent_inst (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(hreq),
      .mute_in(mute), .delay_in(dly), .resp_seen_out(rsp));

   // free-running 100 MHz clock
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // compare one bit, counting every comparison
   task automatic chk(input string nm, input logic s, input logic e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, s);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask

   // reset with a strap value; ends four edges after release
   task automatic rst(input logic s);
      strap      <= s;
      sys_rst_in <= 1'b1;
      repeat (12) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask

   // one host request; answer sampled mid-cycle, ends on a rising edge
   task automatic host(input logic [AW-1:0] a, input logic w,
                       input logic e, input string nm);
      haddr <= a;
      wr    <= w;
      hreq  <= 1'b1;
      @(posedge clk_in);
      hreq  <= 1'b0;
      // answer stands only in the cycle after the request edge
      @(negedge clk_in);
      c_uns = h_uns;
      c_sak = sak;
      if (!wide) chk({nm, " vld"}, h_vld, 1'b1);
      chk(nm, h_clm, e);
      @(posedge clk_in);
   endtask

   // one pci request, checks the forward decision
   task automatic pci(input logic [AW-1:0] a, input logic i,
                      input logic e, input string nm);
      paddr <= a;
      pio   <= i;
      preq  <= 1'b1;
      @(posedge clk_in);
      preq  <= 1'b0;
      @(negedge clk_in);
      chk({nm, " vld"}, p_vld, 1'b1);
      chk(nm, p_fwd, e);
      @(posedge clk_in);
   endtask

   // load the boot rom enable through its pulse port
   task automatic br(input logic v);
      br_val <= v;
      br_wr  <= 1'b1;
      @(posedge clk_in);
      br_wr  <= 1'b0;
      @(posedge clk_in);
   endtask

   initial begin
      // every input has a value at time zero
      {sys_rst_in, strap, hreq, wide, wr, io, ack, smf} = 8'hc0;
      {preq, pio, vbe, tom_en, gap_en, hg_en, br_wr, br_val} = 8'h00;
      {intc, fb_en, sm_en, clr, mute} = 5'h00;
      {haddr, paddr, fra, tmo} = '0;
      {tom, gap_b, hg_lo, hg_hi} = {16'h0100, 16'h0010, 16'h0040, 16'h0041};
      {gap_sz, fb_sz, fb_b} = {3'h0, 3'h0, 12'h800};
      {sm_b, sm_u} = {20'h0000a, 5'h02};
      dly = 4'h1;
      error_cnt = 0;
      samples_checked = 0;
      @(posedge clk_in);
      rst(1'b1);
      // compatibility role: boot rom claimed from reset
      chk("rom en", br_en, 1'b1);
      host(36'h0_000f_0000, 1'b0, 1'b1, "rom rd");
      host(36'h0_000f_ffff, 1'b1, 1'b1, "rom wr");
      br(1'b0);
      host(36'h0_000f_0000, 1'b0, 1'b0, "rom off");
      br(1'b1);
      done("reset");
      // main memory versus top of memory, edges of the top
      host(36'h0_0010_0000, 1'b0, 1'b0, "low");
      host(36'h0_2000_0000, 1'b0, 1'b0, "top off");
      tom_en <= 1'b1;
      host(36'h0_0fff_ffff, 1'b0, 1'b0, "below top");
      host(36'h0_1000_0000, 1'b0, 1'b1, "at top");
      host(36'hf_ffff_ffff, 1'b1, 1'b1, "max");
      tom_en <= 1'b0;
      done("top");
      // video region and all four attribute codes
      host(36'h0_000a_0000, 1'b0, 1'b0, "vid off");
      vbe <= 1'b1;
      host(36'h0_000b_ffff, 1'b0, 1'b1, "vid on");
      pci(36'h0_000a_0000, 1'b0, 1'b0, "pci vid");
      for (int a = 0; a < 4; a++) begin
         fra <= 24'(a);
         host(36'h0_000c_0000, 1'b0, a[0], "attr rd");
         host(36'h0_000c_3fff, 1'b1, a[1], "attr wr");
      end
      fra <= 24'h800000;
      host(36'h0_000e_ffff, 1'b1, 1'b1, "last blk");
      done("fixed");
      // gap sizes either side of the top edge, then no-hit code 6
      gap_en <= 1'b1;
      for (int s = 0; s < 6; s++) begin
         gap_sz <= 3'(s);
         host(36'h0_0100_0000 + (36'h10_0000 << s) - 1, 1'b0, 1'b1,
              "gap in");
         host(36'h0_0100_0000 + (36'h10_0000 << s), 1'b0, 1'b0,
              "gap out");
      end
      pci(36'h0_0100_0000, 1'b0, 1'b0, "pci gap");
      pci(36'h0_0010_0000, 1'b0, 1'b1, "pci low");
      pci(36'h0_2000_0000, 1'b0, 1'b1, "pci top");
      pci(36'h0_0000_0080, 1'b1, 1'b0, "pci io");
      io <= 1'b1;
      host(36'h0_0000_0080, 1'b0, 1'b1, "host io");
      io <= 1'b0;
      gap_sz <= 3'h6;
      host(36'h0_0100_0000, 1'b0, 1'b0, "gap code6");
      gap_en <= 1'b0;
      done("gap");
      // high gap inclusive end, frame buffer smallest and largest
      hg_en <= 1'b1;
      host(36'h0_03ff_ffff, 1'b0, 1'b0, "hg below");
      host(36'h0_0400_0000, 1'b0, 1'b1, "hg start");
      host(36'h0_041f_ffff, 1'b0, 1'b1, "hg end");
      host(36'h0_0420_0000, 1'b0, 1'b0, "hg past");
      hg_en <= 1'b0;
      fb_en <= 1'b1;
      host(36'h0_8000_0000, 1'b0, 1'b1, "fb in");
      host(36'h0_8010_0000, 1'b0, 1'b0, "fb out");
      fb_sz <= 3'h5;
      host(36'h0_81ff_ffff, 1'b0, 1'b1, "fb32 in");
      host(36'h0_8200_0000, 1'b0, 1'b0, "fb32 out");
      fb_en <= 1'b0;
      done("windows");
      // local range and its two exceptions
      {tom, gap_b, gap_en} <= {16'hfff0, 16'h0fed, 1'b1};
      gap_sz <= 3'h0;
      host(36'h0_fed0_0000, 1'b0, 1'b0, "loc rom on");
      br(1'b0);
      host(36'h0_fed0_0000, 1'b0, 1'b1, "loc both off");
      intc <= 1'b1;
      host(36'h0_fed0_0000, 1'b0, 1'b0, "loc intc on");
      {intc, gap_en, tom, tom_en} <= {1'b0, 1'b0, 16'h0100, 1'b1};
      br(1'b1);
      host(36'h0_fed0_0000, 1'b0, 1'b1, "loc above");
      done("local");
      // management ram window over video and above top
      {sm_en, smf} <= 2'b11;
      host(36'h0_000a_0000, 1'b0, 1'b0, "smm vid");
      smf <= 1'b0;
      host(36'h0_000a_0000, 1'b0, 1'b1, "norm vid");
      {sm_b, sm_u, smf} <= {20'h02000, 5'h10, 1'b1};
      host(36'h0_2000_0000, 1'b0, 1'b0, "smm hi");
      host(36'h0_200f_ffff, 1'b0, 1'b0, "smm 1mb");
      host(36'h0_2010_0000, 1'b0, 1'b1, "smm past");
      smf <= 1'b0;
      host(36'h0_2000_0000, 1'b0, 1'b1, "norm hi");
      {sm_u, smf} <= {5'h11, 1'b1};
      host(36'h0_2000_0000, 1'b0, 1'b1, "smm 17");
      done("smm");
      // acknowledge sets and clears the active flag; wide refused
      ack <= 1'b1;
      host(36'h0_0000_0000, 1'b0, 1'b0, "ack on");
      chk("ack rsp", c_sak, 1'b1);
      chk("act set", act, 1'b1);
      {ack, smf} <= 2'b00;
      host(36'h0_0010_0000, 1'b0, 1'b0, "plain");
      chk("act held", act, 1'b1);
      ack <= 1'b1;
      host(36'h0_0000_0000, 1'b0, 1'b0, "ack off");
      chk("act clr", act, 1'b0);
      {ack, wide} <= 2'b01;
      host(36'h0_2010_0000, 1'b0, 1'b0, "wide");
      chk("unsup", c_uns, 1'b1);
      wide <= 1'b0;
      done("ack");
      // silent agent: request times out and is retired
      {tmo, mute} <= {16'h0004, 1'b1};
      host(36'h0_0010_0000, 1'b0, 1'b0, "quiet");
      n = 0;
      while (ret !== 1'b1 && n < 20) begin
         @(negedge clk_in);
         n++;
      end
      // a run-out counts as a mismatch; the run still ends at wrap_up
      if (n == 20) chk("retire wait", 1'b0, 1'b1);
      chk("log", tlog, 1'b1);
      @(negedge clk_in);
      chk("retire 1cyc", ret, 1'b0);
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      {clr, mute, dly} <= {1'b0, 1'b0, 4'h3};
      // slow agent answers before the limit: no new event
      host(36'h0_0010_0000, 1'b0, 1'b0, "slow");
      repeat (12) @(posedge clk_in);
      chk("no log", tlog, 1'b0);
      done("timeout");
      // auxiliary role after a second reset
      rst(1'b0);
      chk("aux rom", br_en, 1'b0);
      host(36'h0_3000_0000, 1'b0, 1'b0, "aux top");
      {ack, smf} <= 2'b11;
      host(36'h0_0000_0000, 1'b0, 1'b0, "aux ack");
      chk("aux rsp", c_sak, 1'b0);
      done("aux");
      wrap_up();
   end
endmodule
